// [pkg/jbs_pkg.sv]
// Constants, types and the scan cell map shared by the boundary-scan test port.
// Assumes the test pins arrive asynchronously and are sampled by the system clock.
package jbs_pkg;

   // ************************************************************
   // Sizes and instruction codes.
   // ************************************************************
   localparam int         BSR_LEN       = 107;
   localparam int         IR_LEN        = 2;
   localparam logic [1:0] IR_EXTEST     = 2'h0;
   localparam logic [1:0] IR_SAMPLE_A   = 2'h1;
   localparam logic [1:0] IR_SAMPLE_B   = 2'h2;
   localparam logic [1:0] IR_BYPASS     = 2'h3;
   localparam logic [1:0] IR_CAPTURE    = 2'h1;
   localparam int         TCK_PERIOD_NS = 160;

   // ************************************************************
   // Cell positions, counted from 1 at the output end of the chain.
   // ************************************************************
   localparam int CELL_PDI_FIRST = 4;
   localparam int CELL_PDI_LAST  = 11;
   localparam int CELL_PDO_FIRST = 15;
   localparam int CELL_PDO_LAST  = 22;
   localparam int CELL_PDO_EN    = 23;

   // ************************************************************
   // Cell kinds and pin reset levels.
   // ************************************************************
   localparam logic [1:0] KIND_IN  = 2'h0;
   localparam logic [1:0] KIND_OUT = 2'h1;
   localparam logic [1:0] KIND_EN  = 2'h2;
   localparam logic [3:0] PIN_IDLE = 4'hf;
   localparam logic [3:0] PIN_PULL = 4'h7;

   // The four test pins travel together: trst_n is bit 0, tck bit 3.
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jbs_tap_pins_type;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
      ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } jbs_tap_state_type;

   // Role of cell n: grouped pins come as enable, output, input triples.
   function automatic logic [1:0] jbs_cell_kind(input int n);
      logic [1:0] k;
      int         r;
      k = KIND_IN;
      // Each triple run starts on its own cell, so the phase is taken from that start.
      r = (n >= 82) ? (n - 82) % 3 : ((n >= 33) ? (n - 33) % 3 : (n - 29) % 3);
      if (n >= 12 && n <= 14) begin
         k = (n == 12) ? KIND_EN : ((n == 13) ? KIND_OUT : KIND_IN);
      end else if (n >= CELL_PDO_FIRST && n <= 27) begin
         k = KIND_OUT;
      end
      if (n == CELL_PDO_EN || n == 58 || n == 81 || n == 106) begin
         k = KIND_EN;
      end else if ((n >= 29 && n <= 31) || (n >= 33 && n <= 56) || (n >= 82 && n <= 105)) begin
         k = (r == 0) ? KIND_EN : ((r == 1) ? KIND_OUT : KIND_IN);
      end else if (n == 59 || n == 60 || n == 107) begin
         k = KIND_OUT;
      end else if (n >= 65 && n <= 80) begin
         k = (((n - 65) % 2) == 0) ? KIND_OUT : KIND_IN;
      end
      return k;
   endfunction : jbs_cell_kind

endpackage : jbs_pkg

// [design/jbs_pin_sync.sv]
// Two-stage synchroniser for asynchronous pins, with optional pull-up on undriven pins.
// Assumes drive is high while something actively drives the matching pin.
`timescale 1ns/1ns
module jbs_pin_sync #(
   parameter int           WIDTH     = 4,
   parameter logic [WIDTH-1:0] PULL  = '1,
   parameter logic [WIDTH-1:0] RESET = '1
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] pin,
   input  wire logic [WIDTH-1:0] drive,
   output logic      [WIDTH-1:0] q
);

   // ************************************************************
   // Pull-up resolution and synchroniser stages.
   // ************************************************************
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_q;

   // An undriven pin reads its pull level; only the second stage is read outside.
   always_comb begin
      next_stage1 = (pin & drive) | (PULL & ~drive);
      next_q      = stage1;
   end

   // Registers only; the clock enable freezes both stages.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stage1 <= RESET;
         q      <= RESET;
      end else if (ce) begin
         stage1 <= next_stage1;
         q      <= next_q;
      end
   end

   // An undriven pulled pin reaches the output two enabled edges later; unpulled bits promise nothing.
   for (genvar b = 0; b < WIDTH; b++) begin : g_pull_chk
      if (PULL[b]) begin : g_pulled
         pull_up_read_a: assert property (@(posedge sys_clk) disable iff (srst)
            (ce && !drive[b]) ##1 ce |=> q[b])
            else $error("undriven pulled pin did not read high");
      end
   end

endmodule : jbs_pin_sync

// [design/jbs_scan_chain.sv]
// Boundary-scan register: shift stages plus update latches, one cell per pin signal.
// Assumes the caller gives one-cycle capture, shift and update pulses.
`timescale 1ns/1ns
module jbs_scan_chain #(
   parameter int LEN = jbs_pkg::BSR_LEN
) (
   input  wire logic           sys_clk,
   input  wire logic           srst,
   input  wire logic           ce,
   input  wire logic           capture,
   input  wire logic           shift,
   input  wire logic           update,
   input  wire logic           tdi,
   input  wire logic [LEN-1:0] cap_data,
   output logic                so,
   output logic      [LEN-1:0] upd
);

   // ************************************************************
   // Per-cell shift and update stages.
   // ************************************************************
   logic [LEN-1:0] sh;
   logic [LEN-1:0] next_sh;
   logic [LEN-1:0] next_upd;

   if (LEN < jbs_pkg::CELL_PDO_EN) begin : g_len_check
      $error("scan chain too short for the pdo enable cell");
   end

   // Cell index 0 sits next to the serial output, so cell 1 leaves first.
   for (genvar i = 0; i < LEN; i++) begin : g_cell
      always_comb begin
         next_sh[i]  = sh[i];
         next_upd[i] = upd[i];
         if (capture) begin
            next_sh[i] = cap_data[i];
         end else if (shift) begin
            next_sh[i] = (i == LEN - 1) ? tdi : sh[(i + 1) % LEN];
         end
         if (update) begin
            next_upd[i] = sh[i];
         end
      end
   end

   // Update latches clear to zero so every enable cell starts with its group tristated.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sh  <= '0;
         upd <= '0;
      end else if (ce) begin
         sh  <= next_sh;
         upd <= next_upd;
      end
   end

   assign so = sh[0];

   // A shift moves serial input into the far cell and shifts the rest toward the output.
   bsr_shift_in_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && shift && !capture) |=> (sh[LEN-1] == $past(tdi)) && (sh[0] == $past(sh[1])))
      else $error("scan chain shift lost a bit");

endmodule : jbs_scan_chain

// [design/jbs_tap.sv]
// Boundary-scan test access port: TAP controller, instruction and bypass registers, TDO.
// Assumes the test pins are asynchronous and that the system clock runs well above the test clock.
//
// Notes on behaviour
// - The controller state moves only on a rising test clock edge, per TMS.
// - TDI is taken on a rising test clock edge while a register shifts.
// - TDO changes only on a falling test clock edge.
// - TDO is tristated whenever neither IR nor DR is shifting.
// - Test reset forces Test-Logic-Reset without waiting for any test clock edge.
// - Undriven TMS, TDI and test reset pins read high.
// - Test logic follows test clock edges only, not the functional clocks.
// - The instruction register is two bits, shifted in during Shift-IR.
// - The instruction picks the active data register and the scan path.
// - TDO carries IR, boundary or bypass bits by state and instruction.
// - Code 00 drives pins from the boundary register and isolates the core.
// - Codes 01 and 10 sample or preload without disturbing the core.
// - Code 11 selects the bypass register; the device works normally.
// - Test reset loads the bypass instruction.
// - The bypass register is one stage from TDI to TDO.
// - The boundary register has 107 cells: input, output or enable.
// - Cell 1 shifts out first; pdo data 15:22, enable 23, pdi 4:11.
// - Enable cells are active high; all zeros tristate every output.
// - Each cell's role is fixed as captured input, driven output or enable.
// - One cell sits between core and each pin buffer.
`timescale 1ns/1ns
module jbs_tap #(
   parameter int LEN = jbs_pkg::BSR_LEN
) (
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   input  wire logic                      ce,
   input  wire jbs_pkg::jbs_tap_pins_type tap_pin,
   input  wire jbs_pkg::jbs_tap_pins_type tap_drive,
   output logic                           tdo,
   output logic                           tdo_oe_n,
   input  wire logic [LEN-1:0]            pin_in,
   input  wire logic [LEN-1:0]            core_out,
   output logic      [LEN-1:0]            pin_drive,
   output logic      [LEN-1:0]            core_in,
   output logic                           extest_active
);

   // ************************************************************
   // Pin sampling and test clock edges.
   // ************************************************************
   jbs_pkg::jbs_tap_pins_type tap_s;
   logic [LEN-1:0]            pin_s;
   logic                      tck_q;
   logic                      next_tck_q;
   logic                      tck_rise;
   logic                      tck_fall;

   // The tck pin has no pull-up; the other three do.
   jbs_pin_sync #(
      .WIDTH (4),
      .PULL  (jbs_pkg::PIN_PULL),
      .RESET (jbs_pkg::PIN_IDLE)
   ) u_tap_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .ce      (ce),
      .pin     (tap_pin),
      .drive   (tap_drive),
      .q       (tap_s)
   );

   // Pin levels for boundary capture are asynchronous too, so they are synchronised.
   jbs_pin_sync #(
      .WIDTH (LEN),
      .PULL  ('0),
      .RESET ('0)
   ) u_pin_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .ce      (ce),
      .pin     (pin_in),
      .drive   ({LEN{1'b1}}),
      .q       (pin_s)
   );

   // Edges of the synchronised test clock are the only timing the test logic uses.
   always_comb begin
      next_tck_q = tap_s.tck;
      tck_rise   = tap_s.tck & ~tck_q;
      tck_fall   = ~tap_s.tck & tck_q;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tck_q <= 1'b1; // Matches the synchroniser's idle level, so release makes no false edge.
      end else if (ce) begin
         tck_q <= next_tck_q;
      end
   end

   // ************************************************************
   // TAP controller.
   // ************************************************************
   jbs_pkg::jbs_tap_state_type state;
   jbs_pkg::jbs_tap_state_type next_state;
   logic                       tms;

   assign tms = tap_s.tms;

   // Standard sixteen-state walk, stepped on rising test clock edges.
   always_comb begin
      next_state = state;
      if (tck_rise) begin
         case (state)
            jbs_pkg::ST_RESET:    next_state = tms ? jbs_pkg::ST_RESET : jbs_pkg::ST_IDLE;
            jbs_pkg::ST_IDLE:     next_state = tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
            jbs_pkg::ST_SEL_DR:   next_state = tms ? jbs_pkg::ST_SEL_IR : jbs_pkg::ST_CAP_DR;
            jbs_pkg::ST_CAP_DR:   next_state = tms ? jbs_pkg::ST_EXIT1_DR : jbs_pkg::ST_SHIFT_DR;
            jbs_pkg::ST_SHIFT_DR: next_state = tms ? jbs_pkg::ST_EXIT1_DR : jbs_pkg::ST_SHIFT_DR;
            jbs_pkg::ST_EXIT1_DR: next_state = tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_PAUSE_DR;
            jbs_pkg::ST_PAUSE_DR: next_state = tms ? jbs_pkg::ST_EXIT2_DR : jbs_pkg::ST_PAUSE_DR;
            jbs_pkg::ST_EXIT2_DR: next_state = tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_SHIFT_DR;
            jbs_pkg::ST_UPD_DR:   next_state = tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
            jbs_pkg::ST_SEL_IR:   next_state = tms ? jbs_pkg::ST_RESET : jbs_pkg::ST_CAP_IR;
            jbs_pkg::ST_CAP_IR:   next_state = tms ? jbs_pkg::ST_EXIT1_IR : jbs_pkg::ST_SHIFT_IR;
            jbs_pkg::ST_SHIFT_IR: next_state = tms ? jbs_pkg::ST_EXIT1_IR : jbs_pkg::ST_SHIFT_IR;
            jbs_pkg::ST_EXIT1_IR: next_state = tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_PAUSE_IR;
            jbs_pkg::ST_PAUSE_IR: next_state = tms ? jbs_pkg::ST_EXIT2_IR : jbs_pkg::ST_PAUSE_IR;
            jbs_pkg::ST_EXIT2_IR: next_state = tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_SHIFT_IR;
            jbs_pkg::ST_UPD_IR:   next_state = tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
            default:              next_state = jbs_pkg::ST_RESET;
         endcase
      end
      // Test reset wins over any edge; it needs no test clock at all.
      if (!tap_s.trst_n) begin
         next_state = jbs_pkg::ST_RESET;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= jbs_pkg::ST_RESET;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Instruction, bypass and output stage.
   // ************************************************************
   logic [jbs_pkg::IR_LEN-1:0] ir_sh;
   logic [jbs_pkg::IR_LEN-1:0] ir;
   logic [jbs_pkg::IR_LEN-1:0] next_ir_sh;
   logic [jbs_pkg::IR_LEN-1:0] next_ir;
   logic                       byp;
   logic                       next_byp;
   logic                       next_tdo;
   logic                       next_tdo_oe_n;
   logic                       sel_byp;
   logic                       shifting;
   logic                       bsr_so;
   logic                       bsr_cap;
   logic                       bsr_shift;
   logic                       bsr_upd;
   logic [LEN-1:0]             bsr_upd_q;
   logic [LEN-1:0]             cap_data;

   // Only code 11 routes the data scan through bypass; the rest use the boundary chain.
   assign sel_byp  = (ir == jbs_pkg::IR_BYPASS);
   assign shifting = (state == jbs_pkg::ST_SHIFT_IR) || (state == jbs_pkg::ST_SHIFT_DR);

   // Capture and shift act on rises, updates and TDO on falls, as the tester expects.
   always_comb begin
      next_ir_sh    = ir_sh;
      next_ir       = ir;
      next_byp      = byp;
      next_tdo      = tdo;
      next_tdo_oe_n = tdo_oe_n;
      if (tck_rise) begin
         if (state == jbs_pkg::ST_CAP_IR) begin
            next_ir_sh = jbs_pkg::IR_CAPTURE;
         end else if (state == jbs_pkg::ST_SHIFT_IR) begin
            next_ir_sh = {tap_s.tdi, ir_sh[1]};
         end
         if (sel_byp && state == jbs_pkg::ST_CAP_DR) begin
            next_byp = 1'b0;
         end else if (sel_byp && state == jbs_pkg::ST_SHIFT_DR) begin
            next_byp = tap_s.tdi;
         end
      end
      if (tck_fall) begin
         if (state == jbs_pkg::ST_UPD_IR) begin
            next_ir = ir_sh;
         end
         // The driver is live only while a register shifts.
         next_tdo_oe_n = ~shifting;
         if (state == jbs_pkg::ST_SHIFT_IR) begin
            next_tdo = ir_sh[0];
         end else if (state == jbs_pkg::ST_SHIFT_DR) begin
            next_tdo = sel_byp ? byp : bsr_so;
         end
      end
      // Test-Logic-Reset, reached by test reset or by TMS, leaves bypass current.
      if (state == jbs_pkg::ST_RESET || !tap_s.trst_n) begin
         next_ir       = jbs_pkg::IR_BYPASS;
         next_tdo_oe_n = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ir_sh    <= jbs_pkg::IR_CAPTURE;
         ir       <= jbs_pkg::IR_BYPASS;
         byp      <= 1'b0;
         tdo      <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (ce) begin
         ir_sh    <= next_ir_sh;
         ir       <= next_ir;
         byp      <= next_byp;
         tdo      <= next_tdo;
         tdo_oe_n <= next_tdo_oe_n;
      end
   end

   // ************************************************************
   // Boundary-scan register and pin muxes.
   // ************************************************************
   // Input cells capture pin levels, output and enable cells what the core drives.
   for (genvar i = 0; i < LEN; i++) begin : g_cap
      assign cap_data[i] = (jbs_pkg::jbs_cell_kind(i + 1) == jbs_pkg::KIND_IN) ? pin_s[i] : core_out[i];
   end

   assign bsr_cap   = tck_rise && !sel_byp && state == jbs_pkg::ST_CAP_DR;
   assign bsr_shift = tck_rise && !sel_byp && state == jbs_pkg::ST_SHIFT_DR;
   assign bsr_upd   = tck_fall && !sel_byp && state == jbs_pkg::ST_UPD_DR;

   jbs_scan_chain #(
      .LEN (LEN)
   ) u_chain (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .ce       (ce),
      .capture  (bsr_cap),
      .shift    (bsr_shift),
      .update   (bsr_upd),
      .tdi      (tap_s.tdi),
      .cap_data (cap_data),
      .so       (bsr_so),
      .upd      (bsr_upd_q)
   );

   // Under external test the chain owns pins and core inputs; otherwise the core runs untouched.
   assign extest_active = (ir == jbs_pkg::IR_EXTEST);
   assign pin_drive     = extest_active ? bsr_upd_q : core_out;
   assign core_in       = extest_active ? bsr_upd_q : pin_in;

   // ************************************************************
   // Checks.
   // ************************************************************
   sequence shift_ir_rise_s;
      ce && tck_rise && state == jbs_pkg::ST_SHIFT_IR && tap_s.trst_n;
   endsequence

   sequence shift_dr_bypass_s;
      ce && tck_rise && state == jbs_pkg::ST_SHIFT_DR && sel_byp && tap_s.trst_n;
   endsequence

   fsm_rise_only_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && !tck_rise && tap_s.trst_n) |=> state == $past(state))
      else $error("TAP state moved without a test clock rise");

   trst_force_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && !tap_s.trst_n) |=> state == jbs_pkg::ST_RESET)
      else $error("test reset did not force Test-Logic-Reset");

   trst_bypass_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && !tap_s.trst_n) |=> ir == jbs_pkg::IR_BYPASS)
      else $error("test reset did not load bypass");

   tdo_on_fall_a: assert property (@(posedge sys_clk) disable iff (srst)
      (tdo != $past(tdo)) |-> $past(ce && tck_fall))
      else $error("TDO changed away from a test clock fall");

   tdo_hiz_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && tck_fall && !shifting) |=> tdo_oe_n)
      else $error("TDO driven outside a shift state");

   ir_shift_in_a: assert property (@(posedge sys_clk) disable iff (srst)
      shift_ir_rise_s |=> ir_sh == {$past(tap_s.tdi), $past(ir_sh[1])})
      else $error("instruction shift lost a bit");

   bypass_one_a: assert property (@(posedge sys_clk) disable iff (srst)
      shift_dr_bypass_s |=> byp == $past(tap_s.tdi))
      else $error("bypass stage did not take TDI");

   bypass_to_tdo_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ce && tck_fall && state == jbs_pkg::ST_SHIFT_DR && sel_byp) |=> !tdo_oe_n && tdo == $past(byp))
      else $error("bypass bit did not reach TDO");

   extest_pins_a: assert property (@(posedge sys_clk) disable iff (srst)
      extest_active |-> pin_drive == bsr_upd_q && core_in == bsr_upd_q)
      else $error("external test left pins to the core");

   sample_core_a: assert property (@(posedge sys_clk) disable iff (srst)
      !extest_active |-> pin_drive == core_out && core_in == pin_in)
      else $error("sample or bypass disturbed the core path");

endmodule : jbs_tap

// [tb/jbs_tester.sv]
// Behavioural model of the external boundary-scan tester on the test port.
// Assumes a 20 ns sys_clk; it makes a 160 ns test clock only while stepping.
`timescale 1ns/1ns
module jbs_tester (
   input  wire logic                 sys_clk,
   input  wire logic                 tdo_wire,
   output jbs_pkg::jbs_tap_pins_type pins,
   output jbs_pkg::jbs_tap_pins_type drv
);
   // ************************************************************
   // Test clock stepping.
   // ************************************************************
   // Low phase is longer so tdo has settled well before we sample it.
   localparam int LOW_CYC = 5;
   initial begin
      pins = 4'h1;
      drv  = 4'hf;
   end
   // One test clock period; tms and tdi move at the fall, tdo is taken before the rise.
   task automatic step(input logic tms, input logic tdi, output logic o);
      @(posedge sys_clk);
      pins.tck <= 1'b0;
      pins.tms <= drv.tms ? tms : pins.tms;
      pins.tdi <= tdi;
      repeat (LOW_CYC - 1) @(posedge sys_clk);
      @(negedge sys_clk);
      o = tdo_wire;
      @(posedge sys_clk);
      pins.tck <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask : step
   task automatic set_trst(input logic v);
      @(posedge sys_clk);
      pins.trst_n <= v;
   endtask : set_trst
   // A released pin carries a low level, so only the pull-up can make it read high.
   task automatic float_tms(input logic f);
      @(posedge sys_clk);
      drv.tms  <= !f;
      pins.tms <= !f;
   endtask : float_tms
endmodule : jbs_tester

// [tb/tb.sv]
// Self-checking bench for the boundary-scan test port.
// Assumes the tester model drives all test pins; core pins are driven here.
`timescale 1ns/1ns
module tb;
   localparam int LEN = jbs_pkg::BSR_LEN;
   logic                      sys_clk;
   logic                      srst;
   logic [LEN-1:0]            pin_in, core_out, pin_drive, core_in, got, pre;
   jbs_pkg::jbs_tap_pins_type pins, drv;
   logic                      tdo, tdo_oe_n, extest_active, o;
   wire                       tdo_wire = tdo_oe_n ? 1'bz : tdo;
   int                        mismatches, cmp_count;
   // ************************************************************
   // Instances and clock.
   // ************************************************************
   jbs_tap #(.LEN(LEN)) u_dut (.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .tap_pin(pins),
      .tap_drive(drv), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
      .pin_drive(pin_drive), .core_in(core_in), .extest_active(extest_active));
   jbs_tester u_tst (.sys_clk(sys_clk), .tdo_wire(tdo_wire), .pins(pins), .drv(drv));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // ************************************************************
   // Shared tasks.
   // ************************************************************
   task automatic check(input logic [LEN-1:0] seen, input logic [LEN-1:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // From Idle: one IR or DR scan of n bits, bit 0 first, back to Idle.
   task automatic scan(input logic ir, input logic [LEN-1:0] din, input int n, output logic [LEN-1:0] dout);
      logic b;
      dout = '0;
      u_tst.step(1'b1, 1'b1, b);
      if (ir) begin
         u_tst.step(1'b1, 1'b1, b);
      end
      u_tst.step(1'b0, 1'b1, b);
      u_tst.step(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         u_tst.step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      u_tst.step(1'b1, 1'b1, b);
      u_tst.step(1'b0, 1'b1, b);
   endtask : scan
   // ************************************************************
   // Scenarios.
   // ************************************************************
   // Bypass after reset: one stage that captures zero, then idle leaves tdo released.
   task automatic t_bypass;
      scan(1'b0, LEN'(8'hb3), 8, got);
      check(got, LEN'(8'h66), "bypass path");
      check(LEN'(tdo_wire), LEN'(1'bz), "tdo idle");
      $display("test bypass done");
   endtask : t_bypass
   // Sample/preload captures pins and core, then code 10 decodes alike.
   task automatic t_sample;
      scan(1'b1, LEN'(2'b01), 2, got);
      check(got, LEN'(2'b01), "ir capture");
      scan(1'b0, pre, LEN, got);
      check(LEN'(got[10:0]), LEN'(pin_in[10:0]), "input cells");
      check(LEN'(got[22:14]), LEN'(core_out[22:14]), "output cells");
      check(pin_drive, core_out, "core undisturbed");
      scan(1'b1, LEN'(2'b10), 2, got);
      check(LEN'(extest_active), LEN'(1'b0), "code 10 not extest");
      $display("test sample done");
   endtask : t_sample
   // External test drives pins from the preloaded cells; all zeros disables the outputs.
   task automatic t_extest;
      scan(1'b1, LEN'(2'b00), 2, got);
      check(LEN'(extest_active), LEN'(1'b1), "extest on");
      check(pin_drive, pre, "pins from cells");
      check(core_in, pre, "core isolated");
      scan(1'b0, '0, LEN, got);
      check(pin_drive, '0, "all outputs off");
      $display("test extest done");
   endtask : t_extest
   // Test reset with no test clock, then a floating tms walks to reset.
   task automatic t_resets;
      u_tst.set_trst(1'b0);
      repeat (6) @(posedge sys_clk);
      u_tst.set_trst(1'b1);
      repeat (4) @(posedge sys_clk);
      check(LEN'(extest_active), LEN'(1'b0), "test reset");
      u_tst.step(1'b0, 1'b1, o);
      scan(1'b1, LEN'(2'b00), 2, got);
      u_tst.float_tms(1'b1);
      repeat (5) u_tst.step(1'b0, 1'b1, o);
      check(LEN'(extest_active), LEN'(1'b0), "tms pull-up");
      u_tst.float_tms(1'b0);
      u_tst.step(1'b0, 1'b1, o);
      $display("test resets done");
   endtask : t_resets
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // ************************************************************
   // Main sequence and watchdog.
   // ************************************************************
   initial begin
      srst = 1'b1;
      pin_in = 107'h2a5_c3c3_9669_0ff0_a5a5_1e2d;
      core_out = 107'h7_5aa5_3cc3_f00f_1248_8421_6dbd;
      pre = 107'h3_6c6c_0ff0_e1e1_5aa5_dead_beef;
      mismatches = 0;
      cmp_count = 0;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      u_tst.step(1'b0, 1'b1, o);
      t_bypass();
      t_sample();
      t_extest();
      t_resets();
      t_bypass();
      tally_and_finish();
   end
   // Whole run needs about 2340 cycles; over thirteen times that means a hang.
   initial begin
      repeat (32000) @(posedge sys_clk);
      mismatches++;
      $display("ERROR at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : tb
